//--- cdsn_pkg.sv
// constants, carrier types and state codes for the clock divide and select network
package cdsn_pkg;

  localparam int NQUAD = 4;
  localparam int NLINE = 8;
  localparam int NSW = 8;
  localparam int NDIV = 2;
  localparam int NSLICE = 3;
  localparam int NSRC = 20;
  localparam int SELW = 5;
  localparam int SYNC_STAGES = 2;

  // register byte offsets
  localparam logic [11:0] OFS_DIV_CTRL = 12'h000;
  localparam logic [11:0] OFS_GATE = 12'h004;
  localparam logic [11:0] OFS_QSEL0 = 12'h008;
  localparam logic [11:0] OFS_SWSEL0 = 12'h00c;
  localparam logic [11:0] OFS_QSTRIDE = 12'h008;
  localparam logic [11:0] OFS_SW_CTRL = 12'h028;
  localparam logic [11:0] OFS_SLICE = 12'h02c;
  localparam logic [11:0] OFS_CASCADE = 12'h030;
  localparam logic [11:0] OFS_STATUS = 12'h034;

  // divider control fields
  localparam int DIV_MODE_POS = 0;
  localparam int DIV_RST_POS = 4;
  localparam int DIV_REL_POS = 6;
  localparam logic [1:0] MODE_DIV2 = 2'h0;
  localparam logic [1:0] MODE_DIV4 = 2'h1;
  localparam logic [1:0] MODE_DIV8 = 2'h2;

  // slice select fields, one 10-bit group per slice
  localparam int SLICE_STRIDE = 10;
  localparam int SLICE_CE_POS = 4;
  localparam int SLICE_SR_POS = 7;

  // values after reset
  localparam logic [7:0] DIV_CTRL_RST = 8'h00;
  localparam logic [31:0] GATE_RST = 32'hffffffff;
  localparam logic [29:0] QSEL_RST = 30'h00000000;
  localparam logic [19:0] SWSEL_RST = 20'h00000;
  localparam logic [7:0] SW_CTRL_RST = 8'h00;
  localparam logic [29:0] SLICE_RST = 30'h00000000;
  localparam logic [3:0] CASCADE_RST = 4'h0;

  // every clock source feeding the centre muxes except the dividers
  typedef struct packed {
    logic [3:0] pll;
    logic [1:0] dll;
    logic [5:0] pin;
    logic [3:0] route;
    logic [1:0] quad;
  } cdsn_src_s;

  typedef enum logic [2:0] {
    SW_ON_A = 3'b001,
    SW_IDLE = 3'b010,
    SW_ON_B = 3'b100
  } cdsn_sw_e;

  function automatic logic [11:0] qsel_ofs(input int q);
    qsel_ofs = 12'(OFS_QSEL0 + OFS_QSTRIDE * q);
  endfunction : qsel_ofs

  function automatic logic [11:0] swsel_ofs(input int q);
    swsel_ofs = 12'(OFS_SWSEL0 + OFS_QSTRIDE * q);
  endfunction : swsel_ofs

endpackage : cdsn_pkg

//--- cdsn_clock_divide_select_network.sv
// clock dividers, quadrant primary muxes with gating, glitchless switches and slice selects
//
// The placing of the registers and the AHB-Lite slave port were left to the implementer.
module cdsn_clock_divide_select_network (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire cdsn_pkg::cdsn_src_s clk_src,
  input wire logic [7:0] secondary_lines,
  output logic [1:0] edge_clock_divider_out,
  output logic [cdsn_pkg::NQUAD*cdsn_pkg::NLINE-1:0] quad_clk,
  output logic [cdsn_pkg::NSLICE-1:0] slice_clk,
  output logic [cdsn_pkg::NSLICE-1:0] slice_ce,
  output logic [cdsn_pkg::NSLICE-1:0] slice_local_set_reset,
  output logic pll_ref,
  output logic dll_ref
);

  ////////////////////////////////////////////////////////////////////////////
  // shared selection functions

  function automatic logic pick(input logic [cdsn_pkg::NSRC-1:0] v, input logic [cdsn_pkg::SELW-1:0] i);
    pick = (int'(i) < cdsn_pkg::NSRC) ? v[i] : 1'b0;
  endfunction : pick

  function automatic logic clk_pick(input logic [3:0] code, input logic [7:0] prim, input logic [7:0] sec);
    if (code == 4'h0) begin
      clk_pick = 1'b1;
    end else if (code <= 4'h8) begin
      clk_pick = prim[3'(code - 4'h1)];
    end else if (code <= 4'hb) begin
      clk_pick = sec[3'(code - 4'h9)];
    end else begin
      clk_pick = sec[3'(code - 4'h8)];
    end
  endfunction : clk_pick

  function automatic logic ctl_pick(input logic [2:0] code, input logic [7:0] sec);
    if (code >= 3'h1 && code <= 3'h4) begin
      ctl_pick = sec[3'(code - 3'h1)];
    end else if (code == 3'h5) begin
      ctl_pick = sec[7];
    end else begin
      ctl_pick = 1'b1;
    end
  endfunction : ctl_pick

  function automatic logic div_bit(input logic [2:0] cnt, input logic [1:0] mode);
    if (mode == cdsn_pkg::MODE_DIV2) begin
      div_bit = cnt[0];
    end else if (mode == cdsn_pkg::MODE_DIV4) begin
      div_bit = cnt[1];
    end else begin
      div_bit = cnt[2];
    end
  endfunction : div_bit

  ////////////////////////////////////////////////////////////////////////////
  // ahb-lite slave, zero wait states
  // a read whose address phase meets a write's data phase to the same word sees the old value

  logic wr_pend_r;
  logic [11:0] wr_addr_r;
  logic [31:0] hrdata_r;
  logic [31:0] rd_mux;
  logic [7:0] div_ctrl_r;
  logic [31:0] gate_r;
  logic [cdsn_pkg::NQUAD-1:0][29:0] qsel_r;
  logic [cdsn_pkg::NQUAD-1:0][19:0] swsel_r;
  logic [7:0] sw_ctrl_r;
  logic [29:0] slice_r;
  logic [3:0] cascade_r;
  logic [31:0] status_w;

  wire addr_ok = hsel & htrans[1] & hready;
  wire [11:0] raddr = haddr[11:0];
  wire wr_div = wr_pend_r && (wr_addr_r == cdsn_pkg::OFS_DIV_CTRL);
  wire wr_gate = wr_pend_r && (wr_addr_r == cdsn_pkg::OFS_GATE);
  wire wr_swctl = wr_pend_r && (wr_addr_r == cdsn_pkg::OFS_SW_CTRL);
  wire wr_slice = wr_pend_r && (wr_addr_r == cdsn_pkg::OFS_SLICE);
  wire wr_casc = wr_pend_r && (wr_addr_r == cdsn_pkg::OFS_CASCADE);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 12'h000;
      hrdata_r <= 32'h00000000;
    end else begin
      wr_pend_r <= addr_ok & hwrite;
      if (addr_ok) begin
        wr_addr_r <= raddr;
      end
      if (addr_ok && !hwrite) begin
        hrdata_r <= rd_mux;
      end
    end
  end

  always_comb begin
    rd_mux = 32'h00000000;
    for (int q = 0; q < cdsn_pkg::NQUAD; q++) begin
      if (raddr == cdsn_pkg::qsel_ofs(q)) begin
        rd_mux = {2'h0, qsel_r[q]};
      end
      if (raddr == cdsn_pkg::swsel_ofs(q)) begin
        rd_mux = {12'h000, swsel_r[q]};
      end
    end
    unique case (raddr)
      cdsn_pkg::OFS_DIV_CTRL: rd_mux = {24'h000000, div_ctrl_r};
      cdsn_pkg::OFS_GATE: rd_mux = gate_r;
      cdsn_pkg::OFS_SW_CTRL: rd_mux = {24'h000000, sw_ctrl_r};
      cdsn_pkg::OFS_SLICE: rd_mux = {2'h0, slice_r};
      cdsn_pkg::OFS_CASCADE: rd_mux = {28'h0000000, cascade_r};
      cdsn_pkg::OFS_STATUS: rd_mux = status_w;
      default: ;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_ctrl_r <= cdsn_pkg::DIV_CTRL_RST;
      gate_r <= cdsn_pkg::GATE_RST;
      sw_ctrl_r <= cdsn_pkg::SW_CTRL_RST;
      slice_r <= cdsn_pkg::SLICE_RST;
      cascade_r <= cdsn_pkg::CASCADE_RST;
    end else begin
      if (wr_div) div_ctrl_r <= hwdata[7:0];
      if (wr_gate) gate_r <= hwdata;
      if (wr_swctl) sw_ctrl_r <= hwdata[7:0];
      if (wr_slice) slice_r <= hwdata[29:0];
      if (wr_casc) cascade_r <= hwdata[3:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      qsel_r <= {cdsn_pkg::NQUAD{cdsn_pkg::QSEL_RST}};
      swsel_r <= {cdsn_pkg::NQUAD{cdsn_pkg::SWSEL_RST}};
    end else begin
      for (int q = 0; q < cdsn_pkg::NQUAD; q++) begin
        if (wr_pend_r && wr_addr_r == cdsn_pkg::qsel_ofs(q)) qsel_r[q] <= hwdata[29:0];
        if (wr_pend_r && wr_addr_r == cdsn_pkg::swsel_ofs(q)) swsel_r[q] <= hwdata[19:0];
      end
    end
  end

  assign hrdata = hrdata_r;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // edge clock dividers, counting at the hclk rate
  // hclk stands in for the fast edge clock; input source selection is not modelled

  logic [cdsn_pkg::NDIV-1:0][cdsn_pkg::SYNC_STAGES-1:0] rel_sync_r;
  logic [cdsn_pkg::NDIV-1:0][2:0] dcnt_r;
  logic [cdsn_pkg::NDIV-1:0][2:0] dcnt_inc;
  logic [cdsn_pkg::NDIV-1:0] dout_r;
  logic [cdsn_pkg::NDIV-1:0] div_rst;
  logic [cdsn_pkg::NDIV-1:0] div_rel;
  logic [cdsn_pkg::NDIV-1:0][1:0] div_mode;

  // a write that sets reset clears the divider on the same edge it lands
  for (genvar d = 0; d < cdsn_pkg::NDIV; d++) begin : g_div
    assign div_rst[d] = div_ctrl_r[cdsn_pkg::DIV_RST_POS+d] | (wr_div & hwdata[cdsn_pkg::DIV_RST_POS+d]);
    assign div_rel[d] = div_ctrl_r[cdsn_pkg::DIV_REL_POS+d];
    assign div_mode[d] = div_ctrl_r[cdsn_pkg::DIV_MODE_POS+2*d +: 2];
    assign dcnt_inc[d] = dcnt_r[d] + 3'h1;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rel_sync_r <= '0;
      dcnt_r <= '0;
      dout_r <= '0;
    end else begin
      for (int d = 0; d < cdsn_pkg::NDIV; d++) begin
        if (div_rst[d]) begin
          rel_sync_r[d] <= '0;
          dcnt_r[d] <= 3'h0;
          dout_r[d] <= 1'b0;
        end else begin
          rel_sync_r[d] <= {rel_sync_r[d][0], div_rel[d]};
          if (rel_sync_r[d][cdsn_pkg::SYNC_STAGES-1]) begin
            dcnt_r[d] <= dcnt_inc[d];
            dout_r[d] <= div_bit(dcnt_inc[d], div_mode[d]);
          end else begin
            dcnt_r[d] <= 3'h0;
            dout_r[d] <= 1'b0;
          end
        end
      end
    end
  end

  assign edge_clock_divider_out = dout_r;

  ////////////////////////////////////////////////////////////////////////////
  // centre muxes and glitchless switches
  // line outputs lag their source by one cycle, switched lines by two

  wire [cdsn_pkg::NSRC-1:0] src_all = {dout_r, clk_src};
  logic [cdsn_pkg::NSW-1:0] sw_a;
  logic [cdsn_pkg::NSW-1:0] sw_b;
  logic [cdsn_pkg::NSW-1:0] sw_out_r;
  logic [cdsn_pkg::NSW-1:0] sw_out_nxt;
  cdsn_pkg::cdsn_sw_e [cdsn_pkg::NSW-1:0] sw_st_r;
  cdsn_pkg::cdsn_sw_e [cdsn_pkg::NSW-1:0] sw_st_nxt;
  logic [cdsn_pkg::NQUAD*cdsn_pkg::NLINE-1:0] raw;

  for (genvar q = 0; q < cdsn_pkg::NQUAD; q++) begin : g_quad
    for (genvar s = 0; s < 2; s++) begin : g_sw
      assign sw_a[q*2+s] = pick(src_all, swsel_r[q][s*10 +: cdsn_pkg::SELW]);
      assign sw_b[q*2+s] = pick(src_all, swsel_r[q][s*10+5 +: cdsn_pkg::SELW]);
    end
    for (genvar l = 0; l < cdsn_pkg::NLINE; l++) begin : g_line
      if (l < 6) begin : g_mux
        // every quadrant uses the same mux over the same sources
        assign raw[q*8+l] = pick(src_all, qsel_r[q][l*5 +: cdsn_pkg::SELW]);
      end else begin : g_swl
        assign raw[q*8+l] = sw_out_r[q*2+l-6];
      end
    end
  end

  // a side is left or taken only while that clock is low, so no pulse is cut short
  always_comb begin
    for (int k = 0; k < cdsn_pkg::NSW; k++) begin
      sw_st_nxt[k] = sw_st_r[k];
      unique case (sw_st_r[k])
        cdsn_pkg::SW_ON_A: if (sw_ctrl_r[k] && !sw_a[k]) sw_st_nxt[k] = cdsn_pkg::SW_IDLE;
        cdsn_pkg::SW_ON_B: if (!sw_ctrl_r[k] && !sw_b[k]) sw_st_nxt[k] = cdsn_pkg::SW_IDLE;
        cdsn_pkg::SW_IDLE: begin
          if (sw_ctrl_r[k] && !sw_b[k]) begin
            sw_st_nxt[k] = cdsn_pkg::SW_ON_B;
          end else if (!sw_ctrl_r[k] && !sw_a[k]) begin
            sw_st_nxt[k] = cdsn_pkg::SW_ON_A;
          end
        end
        default: sw_st_nxt[k] = cdsn_pkg::SW_IDLE;
      endcase
      sw_out_nxt[k] = ((sw_st_nxt[k] == cdsn_pkg::SW_ON_A) & sw_a[k]) | ((sw_st_nxt[k] == cdsn_pkg::SW_ON_B) & sw_b[k]);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int k = 0; k < cdsn_pkg::NSW; k++) begin
        sw_st_r[k] <= cdsn_pkg::SW_ON_A;
      end
      sw_out_r <= '0;
    end else begin
      sw_st_r <= sw_st_nxt;
      sw_out_r <= sw_out_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // quadrant gating
  // a gate bit is taken over only while its raw line is low, so no high phase is cut short

  logic [cdsn_pkg::NQUAD*cdsn_pkg::NLINE-1:0] gate_eff_r;
  logic [cdsn_pkg::NQUAD*cdsn_pkg::NLINE-1:0] quad_clk_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gate_eff_r <= cdsn_pkg::GATE_RST;
      quad_clk_r <= '0;
    end else begin
      gate_eff_r <= (gate_eff_r & raw) | (gate_r & ~raw);
      quad_clk_r <= raw & gate_eff_r;
    end
  end

  assign quad_clk = quad_clk_r;

  ////////////////////////////////////////////////////////////////////////////
  // slice clock and control selects for slices 0 to 2; slice 3 has none

  logic [cdsn_pkg::NSLICE-1:0] sl_clk_r;
  logic [cdsn_pkg::NSLICE-1:0] sl_ce_r;
  logic [cdsn_pkg::NSLICE-1:0] sl_sr_r;
  logic [cdsn_pkg::NSLICE-1:0] sl_clk_w;
  logic [cdsn_pkg::NSLICE-1:0] sl_ce_w;
  logic [cdsn_pkg::NSLICE-1:0] sl_sr_w;

  // the block sits in quadrant 0 and in one secondary region of eight lines
  // codes outside the table give a constant one, so an unused slice stays enabled
  for (genvar s = 0; s < cdsn_pkg::NSLICE; s++) begin : g_slice
    assign sl_clk_w[s] = clk_pick(slice_r[s*cdsn_pkg::SLICE_STRIDE +: 4], quad_clk_r[7:0], secondary_lines);
    assign sl_ce_w[s] = ctl_pick(slice_r[s*cdsn_pkg::SLICE_STRIDE+cdsn_pkg::SLICE_CE_POS +: 3], secondary_lines);
    assign sl_sr_w[s] = ctl_pick(slice_r[s*cdsn_pkg::SLICE_STRIDE+cdsn_pkg::SLICE_SR_POS +: 3], secondary_lines);
  end

  ////////////////////////////////////////////////////////////////////////////
  // pll cascade: codes 1 to 3 feed pll output 0 to 2 to a reference input
  // code zero falls back to a pin, so a reference input never floats

  wire pll_ref_w = (cascade_r[1:0] == 2'h0) ? clk_src.pin[0] : clk_src.pll[2'(cascade_r[1:0] - 2'h1)];
  wire dll_ref_w = (cascade_r[3:2] == 2'h0) ? clk_src.pin[1] : clk_src.pll[2'(cascade_r[3:2] - 2'h1)];
  logic pll_ref_r;
  logic dll_ref_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sl_clk_r <= {cdsn_pkg::NSLICE{1'b1}};
      sl_ce_r <= {cdsn_pkg::NSLICE{1'b1}};
      sl_sr_r <= {cdsn_pkg::NSLICE{1'b1}};
      pll_ref_r <= 1'b0;
      dll_ref_r <= 1'b0;
    end else begin
      sl_clk_r <= sl_clk_w;
      sl_ce_r <= sl_ce_w;
      sl_sr_r <= sl_sr_w;
      pll_ref_r <= pll_ref_w;
      dll_ref_r <= dll_ref_w;
    end
  end

  assign slice_clk = sl_clk_r;
  assign slice_ce = sl_ce_r;
  assign slice_local_set_reset = sl_sr_r;
  assign pll_ref = pll_ref_r;
  assign dll_ref = dll_ref_r;

  ////////////////////////////////////////////////////////////////////////////
  // status: bits 1:0 release seen, 3:2 divider outputs, 15:8 on input b, 23:16 switching
  // read only; writes to this word are dropped

  always_comb begin
    status_w = 32'h00000000;
    for (int d = 0; d < cdsn_pkg::NDIV; d++) begin
      status_w[d] = rel_sync_r[d][cdsn_pkg::SYNC_STAGES-1];
      status_w[2+d] = dout_r[d];
    end
    for (int k = 0; k < cdsn_pkg::NSW; k++) begin
      status_w[8+k] = (sw_st_r[k] == cdsn_pkg::SW_ON_B);
      status_w[16+k] = (sw_st_r[k] == cdsn_pkg::SW_IDLE);
    end
  end

endmodule : cdsn_clock_divide_select_network

//--- cdsn_chk.sv
// port checker for the clock divide and select network
module cdsn_chk (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hready,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic [1:0] edge_clock_divider_out,
  input wire logic [31:0] quad_clk,
  input wire logic [2:0] slice_clk,
  input wire logic [2:0] slice_ce,
  input wire logic [2:0] slice_local_set_reset
);
  logic wp_r;
  logic [11:0] wa_r;
  logic [7:0] div_r;
  logic [2:0] qt_r;
  wire dw = wp_r && (wa_r == cdsn_pkg::OFS_DIV_CTRL);
  wire d0 = edge_clock_divider_out[0];
  wire rel_new = dw && (hwdata[6:4] == 3'h4) && !div_r[6];
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wp_r <= 1'b0;
      wa_r <= 12'h000;
      div_r <= 8'h00;
      qt_r <= 3'h0;
    end else begin
      wp_r <= hsel && htrans[1] && hready && hwrite;
      wa_r <= haddr[11:0];
      div_r <= dw ? hwdata[7:0] : div_r;
      // mux and switch input changes may cut pulses; judge only quiet stretches
      qt_r <= wp_r ? 3'h0 : ((qt_r == 3'h7) ? qt_r : qt_r + 3'h1);
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_quarter;
    d0 ##1 !d0;
  endsequence
  sequence s_first;
    ##4 d0 ##1 !d0;
  endsequence
  property p_div_half;
    ($rose(d0) && div_r[1:0] == 2'h0) |=> !d0;
  endproperty
  property p_div_quarter;
    ($rose(d0) && div_r[1:0] == 2'h1) |=> s_quarter;
  endproperty
  property p_div_rst;
    (dw && hwdata[5:4] == 2'h3) |=> (edge_clock_divider_out == 2'h0);
  endproperty
  property p_rel_sync;
    rel_new |-> (!d0) [*3];
  endproperty
  property p_rel_phase;
    (rel_new && hwdata[1:0] == 2'h0) |-> s_first;
  endproperty
  property p_gate_off;
    (wp_r && wa_r == cdsn_pkg::OFS_GATE && hwdata == 32'h0) |-> ##[2:20] (quad_clk == 32'h0) [*8];
  endproperty
  property p_slice_one;
    (wp_r && wa_r == cdsn_pkg::OFS_SLICE && hwdata[29:0] == 30'h0)
      |-> ##2 ((slice_clk & slice_ce & slice_local_set_reset) == 3'h7) [*4];
  endproperty
  property p_switch_clean;
    (qt_r == 3'h7) |-> !(|($past(quad_clk[7:6]) & ~$past(quad_clk[7:6], 2) & ~quad_clk[7:6]));
  endproperty
  property p_gate_clean;
    (qt_r == 3'h7) |-> !(|($past(quad_clk[5:0]) & ~$past(quad_clk[5:0], 2) & ~quad_clk[5:0]));
  endproperty
  a_div_half: assert property (p_div_half) else $error("half rate high too long");
  a_div_quarter: assert property (p_div_quarter) else $error("quarter rate shape wrong");
  a_div_rst: assert property (p_div_rst) else $error("divider reset left output high");
  a_rel_sync: assert property (p_rel_sync) else $error("release not synchronised");
  a_rel_phase: assert property (p_rel_phase) else $error("first divided edge misplaced");
  a_gate_off: assert property (p_gate_off) else $error("gated lines still toggle");
  a_slice_one: assert property (p_slice_one) else $error("unselected slice mux not one");
  a_switch_clean: assert property (p_switch_clean) else $error("runt on switched line");
  a_gate_clean: assert property (p_gate_clean) else $error("runt on gated line");
endmodule : cdsn_chk

//--- cdsn_src_model.sv
// free running fabric clock sources, every pulse at least two cycles wide
module cdsn_src_model (
  input wire logic hclk,
  input wire logic hresetn,
  output cdsn_pkg::cdsn_src_s clk_src,
  output logic [7:0] secondary_lines
);
  logic [25:0] lv;
  int cnt [26];
  assign clk_src = lv[17:0];
  assign secondary_lines = lv[25:18];
  always @(posedge hclk or negedge hresetn) begin
    for (int i = 0; i < 26; i++) begin
      if (!hresetn) begin
        lv[i] <= 1'b0;
        cnt[i] <= 0;
      end else if (cnt[i] >= 1 + i % 5) begin
        cnt[i] <= 0;
        lv[i] <= ~lv[i];
      end else begin
        cnt[i] <= cnt[i] + 1;
      end
    end
  end
endmodule : cdsn_src_model

//--- tb_top.sv
// register driven bench for the clock divide and select network
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic hclk;
  logic hresetn;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  cdsn_pkg::cdsn_src_s clk_src;
  logic [7:0] secondary_lines;
  logic [1:0] edge_clock_divider_out;
  logic [31:0] quad_clk;
  logic [2:0] slice_clk;
  logic [2:0] slice_ce;
  logic [2:0] slice_local_set_reset;
  logic pll_ref;
  logic dll_ref;
  int n_errors;
  int check_count;
  int n;
  logic p;
  logic [31:0] rd;
  logic [60:0] h1;
  logic [60:0] h2;
  int sidx [6] = '{0, 2, 6, 12, 14, 17};
  int qs [3] = '{0, 2, 3};
  int so [9] = '{32, 35, 38, 33, 36, 39, 34, 37, 40};
  int ss [9] = '{20, 27, 20, 24, 23, 60, 28, 60, 60};
  wire [42:0] ov = {dll_ref, pll_ref, slice_local_set_reset, slice_ce, slice_clk, quad_clk};
  wire [60:0] sv = {1'b1, quad_clk, secondary_lines, edge_clock_divider_out, clk_src};
  cdsn_clock_divide_select_network i_cdsn_clock_divide_select_network (.hclk(hclk), .hresetn(hresetn),
    .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .clk_src(clk_src),
    .secondary_lines(secondary_lines), .edge_clock_divider_out(edge_clock_divider_out), .quad_clk(quad_clk),
    .slice_clk(slice_clk), .slice_ce(slice_ce), .slice_local_set_reset(slice_local_set_reset),
    .pll_ref(pll_ref), .dll_ref(dll_ref));
  cdsn_src_model i_cdsn_src_model (.hclk(hclk), .hresetn(hresetn), .clk_src(clk_src),
    .secondary_lines(secondary_lines));
  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end
  // history of every source, one and two cycles back
  always @(posedge hclk) begin
    h1 <= sv;
    h2 <= h1;
  end
  task automatic complete_run();
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : complete_run
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge hclk);
    haddr <= {20'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : xfer
  task automatic rdchk(input string nm, input logic [11:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(nm, e, rd);
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask : rdchk
  // output o must repeat source s after lag cycles
  task automatic trk(input string nm, input int o, input int s, input int lag);
    repeat (2) @(posedge hclk);
    repeat (12) begin
      @(posedge hclk);
      #1;
      chk(nm, {31'h0, (lag == 1) ? h1[s] : h2[s]}, {31'h0, ov[o]});
    end
  endtask : trk
  initial begin
    repeat (5000) @(posedge hclk);
    n_errors++;
    complete_run();
  end
  initial begin
    hresetn = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    rdchk("gate reset", 12'h004, 32'hffffffff);
    rdchk("div reset", 12'h000, 32'h0);
    rdchk("switch reset", 12'h028, 32'h0);
    chk("slice reset", 32'h1ff, {23'h0, slice_clk, slice_ce, slice_local_set_reset});
    xfer(1'b1, 12'h0fc, 32'h12345678);
    rdchk("unmapped", 12'h0fc, 32'h0);
    xfer(1'b1, 12'h010, 32'h272);
    for (int m = 0; m < 4; m++) begin
      xfer(1'b1, 12'h000, 32'h30 + 32'(m * 5));
      #1;
      chk("div held low", 32'h0, {30'h0, edge_clock_divider_out});
      xfer(1'b1, 12'h000, 32'hc0 + 32'(m * 5));
      repeat (8) @(posedge hclk);
      #1;
      n = 0;
      p = edge_clock_divider_out[0];
      repeat (64) begin
        @(posedge hclk);
        #1;
        if (edge_clock_divider_out[0] && !p) n++;
        p = edge_clock_divider_out[0];
      end
      chk("div rate", 32'd32 >> ((m > 2) ? 2 : m), 32'(n));
      trk("div0 line", 8, 18, 1);
      trk("div1 line", 9, 19, 1);
    end
    foreach (qs[k]) begin
      xfer(1'b1, cdsn_pkg::qsel_ofs(qs[k]), 32'h22e61840);
      rdchk("qsel", cdsn_pkg::qsel_ofs(qs[k]), 32'h22e61840);
      for (int l = 0; l < 6; l++) trk("primary", qs[k] * 8 + l, sidx[l], 1);
    end
    xfer(1'b1, 12'h00c, 32'h638c2);
    trk("switch a", 6, 2, 2);
    trk("switch a", 7, 14, 2);
    xfer(1'b1, 12'h028, 32'h3);
    repeat (30) @(posedge hclk);
    trk("switch b", 6, 6, 2);
    trk("switch b", 7, 12, 2);
    xfer(1'b1, 12'h000, 32'h30);
    rdchk("status", 12'h034, 32'h300);
    xfer(1'b1, 12'h02c, 32'h301f30d9);
    foreach (so[k]) trk("slice", so[k], ss[k], 1);
    xfer(1'b1, 12'h02c, 32'h0);
    repeat (3) @(posedge hclk);
    chk("slice idle", 32'h1ff, {23'h0, slice_clk, slice_ce, slice_local_set_reset});
    xfer(1'b1, 12'h030, 32'h1);
    trk("pll ref", 41, 14, 1);
    trk("dll ref", 42, 7, 1);
    xfer(1'b1, 12'h030, 32'hf);
    trk("pll ref", 41, 16, 1);
    trk("dll ref", 42, 16, 1);
    xfer(1'b1, 12'h004, 32'h0);
    repeat (30) @(posedge hclk);
    repeat (8) begin
      @(posedge hclk);
      #1;
      chk("gated", 32'h0, quad_clk);
    end
    xfer(1'b1, 12'h004, 32'hffffffff);
    trk("ungated", 0, 0, 1);
    complete_run();
  end
endmodule : tb_top
bind cdsn_clock_divide_select_network cdsn_chk i_cdsn_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hready(hready), .hwrite(hwrite), .hwdata(hwdata),
  .edge_clock_divider_out(edge_clock_divider_out), .quad_clk(quad_clk), .slice_clk(slice_clk),
  .slice_ce(slice_ce), .slice_local_set_reset(slice_local_set_reset));
